// ### design/wdrl_consts.svh
`ifndef WDRL_CONSTS_SVH
`define WDRL_CONSTS_SVH
// Register write addresses on the core's write port
`define WDRL_ADDR_CONTROL  8'hF0
`define WDRL_ADDR_UPPER    8'hF1
`define WDRL_ADDR_HIGH     8'hF2
`define WDRL_ADDR_LOW      8'hF3
// Unlock key bytes
`define WDRL_KEY_FIRST     8'h55
`define WDRL_KEY_SECOND    8'hAA
// Reload value after reset
`define WDRL_RELOAD_RESET  24'hFFFFFF
`define WDRL_COUNT_ZERO    24'h000000
`define WDRL_COUNT_ONE     24'h000001
// Per-byte reload reset, matching the 24-bit reset value
`define WDRL_BYTE_RESET    8'hFF
`define WDRL_CONTROL_RESET 8'h00
// Asynchronous pins passed through the synchronisers
`define WDRL_PIN_COUNT     4
`endif

// ### design/wdrl_pkg.sv
package wdrl_pkg;
  // Lock sequencer states, one-hot
  typedef enum logic [4:0] {
    LOCKED    = 5'h01,
    GOT_FIRST = 5'h02,
    OPEN_U    = 5'h04,
    OPEN_H    = 5'h08,
    OPEN_L    = 5'h10
  } wdrl_lock_t;

  // One register write from the core
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } wdrl_write_t;
endpackage

// ### design/wdrl_watchdog.sv
// How it works
// - Reset-mode time-out in normal run requests system reset, sets time-out flag.
// - Reset-mode time-out in stop mode requests recovery, sets time-out and stop flags.
// - Unlock writes to the control address leave control bits unchanged.
// - After unlock, upper, high, then low reload bytes are written in order.
// - Any other write mid-sequence returns the sequencer to locked.
// - Reload byte writes are ignored while locked.
// - Counter loads reload value on first enable and on every refresh.
`include "wdrl_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module wdrl_watchdog (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // Register writes and refresh from the core
  input  wire wdrl_pkg::wdrl_write_t regWrite,
  input  wire logic               refresh,
  // Watchdog oscillator tick and mode inputs (asynchronous)
  input  wire logic               wdOscTick,
  input  wire logic               enable,
  input  wire logic               resetMode,
  input  wire logic               inStop,
  // Status to the core
  output logic [7:0]              watchdogControl,
  output logic [23:0]             reloadValue,
  output logic [23:0]             countValue,
  output logic [1:0]              resetCauseFlags,
  // Reset controller requests
  output logic                    sysResetReq,
  output logic                    stopRecoveryReq,
  output logic                    timeoutPulse
);
  logic rstSync1_q, rstSync2_q;
  logic [3:0] pinSync1_q, pinSync2_q;
  logic [3:0] pinRaw;
  logic tickPrev_q, enPrev_q;
  logic tickEn, enRise, timeout;
  logic tickSync, enSync, modeSync, stopSync;
  wdrl_pkg::wdrl_lock_t lock_q;
  logic [7:0] upper_q, high_q;
  logic [23:0] count_q;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end
    else
    begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  // Raw pins in sync order: stop, mode, enable, tick
  assign pinRaw = {inStop, resetMode, enable, wdOscTick};

  // One two-flop chain per pin; nothing reads the first flop but the second
  genvar pinIdx;
  for (pinIdx = 0; pinIdx < `WDRL_PIN_COUNT; pinIdx++)
  begin : g_pinSync
    always_ff @(posedge clk or negedge rstSync2_q)
    begin
      if (!rstSync2_q)
      begin
        pinSync1_q[pinIdx] <= 1'b0;
        pinSync2_q[pinIdx] <= 1'b0;
      end
      else
      begin
        pinSync1_q[pinIdx] <= pinRaw[pinIdx];
        pinSync2_q[pinIdx] <= pinSync1_q[pinIdx];
      end
    end
  end

  // Named views of the synchronised pins
  assign tickSync = pinSync2_q[0];
  assign enSync   = pinSync2_q[1];
  assign modeSync = pinSync2_q[2];
  assign stopSync = pinSync2_q[3];

  // Edge history, read only after the second flop
  always_ff @(posedge clk or negedge rstSync2_q)
  begin
    if (!rstSync2_q)
    begin
      tickPrev_q <= 1'b0;
      enPrev_q   <= 1'b0;
    end
    else
    begin
      tickPrev_q <= pinSync2_q[0];
      enPrev_q   <= pinSync2_q[1];
    end
  end

  // Edge history resets low, the idle level of both pins, so no false edge
  assign tickEn = tickSync & ~tickPrev_q;
  // An enable already high at reset release still counts as first enable
  assign enRise = enSync & ~enPrev_q;

  // Lock sequencer; any write off the expected path relocks
  always_ff @(posedge clk or negedge rstSync2_q)
  begin
    if (!rstSync2_q)
      lock_q <= wdrl_pkg::LOCKED;
    else if (regWrite.valid)
    begin
      case (lock_q)
        wdrl_pkg::LOCKED:
          lock_q <= (regWrite.addr == `WDRL_ADDR_CONTROL &&
                     regWrite.data == `WDRL_KEY_FIRST)
                    ? wdrl_pkg::GOT_FIRST : wdrl_pkg::LOCKED;
        wdrl_pkg::GOT_FIRST:
          lock_q <= (regWrite.addr == `WDRL_ADDR_CONTROL &&
                     regWrite.data == `WDRL_KEY_SECOND)
                    ? wdrl_pkg::OPEN_U : wdrl_pkg::LOCKED;
        wdrl_pkg::OPEN_U:
          lock_q <= (regWrite.addr == `WDRL_ADDR_UPPER)
                    ? wdrl_pkg::OPEN_H : wdrl_pkg::LOCKED;
        wdrl_pkg::OPEN_H:
          lock_q <= (regWrite.addr == `WDRL_ADDR_HIGH)
                    ? wdrl_pkg::OPEN_L : wdrl_pkg::LOCKED;
        wdrl_pkg::OPEN_L:
          lock_q <= wdrl_pkg::LOCKED;
        default:
          lock_q <= wdrl_pkg::LOCKED;
      endcase
    end
  end

  // Control register: key writes never land, other writes do
  always_ff @(posedge clk or negedge rstSync2_q)
  begin
    if (!rstSync2_q)
      watchdogControl <= `WDRL_CONTROL_RESET;
    else if (regWrite.valid && regWrite.addr == `WDRL_ADDR_CONTROL &&
             regWrite.data != `WDRL_KEY_FIRST &&
             regWrite.data != `WDRL_KEY_SECOND)
      watchdogControl <= regWrite.data;
  end

  // Reload bytes; staged upper/high so the period changes only at low
  always_ff @(posedge clk or negedge rstSync2_q)
  begin
    if (!rstSync2_q)
    begin
      upper_q     <= `WDRL_BYTE_RESET;
      high_q      <= `WDRL_BYTE_RESET;
      reloadValue <= `WDRL_RELOAD_RESET;
    end
    else if (regWrite.valid)
    begin
      if (lock_q == wdrl_pkg::OPEN_U && regWrite.addr == `WDRL_ADDR_UPPER)
        upper_q <= regWrite.data;
      if (lock_q == wdrl_pkg::OPEN_H && regWrite.addr == `WDRL_ADDR_HIGH)
        high_q <= regWrite.data;
      if (lock_q == wdrl_pkg::OPEN_L && regWrite.addr == `WDRL_ADDR_LOW)
        reloadValue <= {upper_q, high_q, regWrite.data};
    end
  end

  // Down counter on oscillator ticks
  assign timeout = pinSync2_q[1] && tickEn && count_q == `WDRL_COUNT_ONE;
  always_ff @(posedge clk or negedge rstSync2_q)
  begin
    if (!rstSync2_q)
      count_q <= `WDRL_RELOAD_RESET;
    else if (enRise || refresh || timeout)
      count_q <= reloadValue;
    else if (pinSync2_q[1] && tickEn && count_q != `WDRL_COUNT_ZERO)
      count_q <= count_q - `WDRL_COUNT_ONE;
  end
  assign countValue = count_q;

  // Reset-cause flags and reset requests; flags clear only on power reset
  always_ff @(posedge clk or negedge rstSync2_q)
  begin
    if (!rstSync2_q)
    begin
      resetCauseFlags <= 2'h0;
      sysResetReq     <= 1'b0;
      stopRecoveryReq <= 1'b0;
      timeoutPulse    <= 1'b0;
    end
    else
    begin
      timeoutPulse    <= timeout;
      sysResetReq     <= timeout && pinSync2_q[2] && !pinSync2_q[3];
      stopRecoveryReq <= timeout && pinSync2_q[2] && pinSync2_q[3];
      // OR in, so a later run-mode time-out keeps an earlier stop cause
      if (timeout && modeSync)
        resetCauseFlags <= resetCauseFlags | {stopSync, 1'b1};
    end
  end
endmodule
`default_nettype wire

// ### verif/wdrl_watchdog_properties.sv
`include "wdrl_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module wdrl_watchdog_properties (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rstn,
  // Core side
  input wire wdrl_pkg::wdrl_write_t regWrite,
  input wire logic                  refresh,
  // Status and requests
  input wire logic [7:0]            watchdogControl,
  input wire logic [23:0]           reloadValue,
  input wire logic [23:0]           countValue,
  input wire logic [1:0]            resetCauseFlags,
  input wire logic                  sysResetReq,
  input wire logic                  stopRecoveryReq,
  input wire logic                  timeoutPulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // One valid write to a given address
  sequence wrAt(logic [7:0] a);
    regWrite.valid && regWrite.addr == a;
  endsequence
  // Both key writes, back to back
  sequence keysSeq;
    regWrite == {1'b1, `WDRL_ADDR_CONTROL, `WDRL_KEY_FIRST} ##1
    regWrite == {1'b1, `WDRL_ADDR_CONTROL, `WDRL_KEY_SECOND};
  endsequence
  AST_KEEP: assert property (keysSeq |=> watchdogControl == $past(watchdogControl, 2))
    else $error("control changed by key write");
  AST_LOAD: assert property (keysSeq ##1 wrAt(`WDRL_ADDR_UPPER) ##1
    wrAt(`WDRL_ADDR_HIGH) ##1 wrAt(`WDRL_ADDR_LOW) |=> reloadValue ==
    {$past(regWrite.data, 3), $past(regWrite.data, 2), $past(regWrite.data)})
    else $error("reload value not taken from sequence");
  AST_BREAK: assert property (keysSeq ##1 (regWrite.valid &&
    regWrite.addr != `WDRL_ADDR_UPPER) ##1 wrAt(`WDRL_ADDR_UPPER) ##1
    wrAt(`WDRL_ADDR_HIGH) ##1 wrAt(`WDRL_ADDR_LOW) |=> $stable(reloadValue))
    else $error("reload changed after broken sequence");
  AST_LOCKED: assert property ($changed(reloadValue) |->
    $past(regWrite.valid && regWrite.addr == `WDRL_ADDR_LOW))
    else $error("reload changed without low byte write");
  AST_REFRESH: assert property (refresh |=> countValue == reloadValue)
    else $error("refresh did not load counter");
  AST_ZERO: assert property (timeoutPulse |->
    $past(countValue) == `WDRL_COUNT_ONE && countValue == reloadValue)
    else $error("time-out not at end of count");
  AST_REQ: assert property (sysResetReq || stopRecoveryReq |-> timeoutPulse)
    else $error("reset request without time-out");
  AST_SYSFLAG: assert property (sysResetReq |=> resetCauseFlags[0])
    else $error("time-out flag not set");
  AST_STOPFLAG: assert property (stopRecoveryReq |=> &resetCauseFlags)
    else $error("stop flags not set");
endmodule
bind wdrl_watchdog wdrl_watchdog_properties props (.*);
`default_nettype wire

// ### verif/wdrl_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module wdrl_core_model (
  // Core side of the write port
  input  wire logic             clk,
  output wdrl_pkg::wdrl_write_t regWrite,
  output logic                  refresh
);
  initial regWrite = '0;
  initial refresh = 1'b0;
  // Writes stay valid edge to edge so a sequence is back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) regWrite <= {1'b1, a, d};
  endtask
  // Released fields show inverted junk, not the last value
  task automatic idle;
    @(posedge clk) regWrite <= {1'b0, ~regWrite.addr, ~regWrite.data};
  endtask
  // Refresh instruction, one cycle
  task automatic kick;
    @(posedge clk) refresh <= 1'b1;
    @(posedge clk) refresh <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verif/watchdog_reload_lock_and_reset_test.sv
`include "wdrl_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module watchdog_reload_lock_and_reset_test;
  logic clk, rstn, tick, enable, resetMode, inStop, refresh, sysReq, stopReq;
  logic pulse;
  wdrl_pkg::wdrl_write_t regWrite;
  logic [7:0] ctl;
  logic [23:0] rel, cnt;
  logic [1:0] flags;
  int badCount, checkCount, cyc, nSys, nStop, nPulse;
  wdrl_core_model core (.clk(clk), .regWrite(regWrite), .refresh(refresh));
  wdrl_watchdog DUT (.clk(clk), .rstn(rstn), .regWrite(regWrite),
    .refresh(refresh), .wdOscTick(tick), .enable(enable),
    .resetMode(resetMode), .inStop(inStop), .watchdogControl(ctl),
    .reloadValue(rel), .countValue(cnt), .resetCauseFlags(flags),
    .sysResetReq(sysReq), .stopRecoveryReq(stopReq), .timeoutPulse(pulse));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Request counters and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    nSys <= nSys + int'(sysReq === 1'b1);
    nStop <= nStop + int'(stopReq === 1'b1);
    nPulse <= nPulse + int'(pulse === 1'b1);
    if (cyc == 3000)
    begin
      badCount++;
      endOfTest;
    end
  end
  task automatic cmp(input string n, input logic [23:0] e, g);
    checkCount++;
    if (g !== e)
    begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Let the edge's updates land before sampling
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Slow oscillator: each tick spans thirteen core cycles
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk) tick <= 1'b1;
      repeat (6) @(posedge clk);
      tick <= 1'b0;
      repeat (6) @(posedge clk);
    end
    settle(5);
  endtask
  task automatic keysAnd(input logic [7:0] d);
    core.wr(`WDRL_ADDR_CONTROL, `WDRL_KEY_FIRST);
    core.wr(`WDRL_ADDR_CONTROL, `WDRL_KEY_SECOND);
    if (d != 8'h00)
      core.wr(`WDRL_ADDR_CONTROL, d);
    core.wr(`WDRL_ADDR_UPPER, 8'h00);
    core.wr(`WDRL_ADDR_HIGH, 8'h00);
    core.wr(`WDRL_ADDR_LOW, 8'h03);
    core.idle;
    settle(2);
  endtask
  task automatic tBroken;
    keysAnd(8'h12);
    cmp("stray reload", `WDRL_RELOAD_RESET, rel);
    cmp("control", 24'h000012, {16'h0000, ctl});
  endtask
  task automatic tReload;
    keysAnd(8'h00);
    cmp("control", 24'h000012, {16'h0000, ctl});
    cmp("reload", 24'h000003, rel);
    @(posedge clk) enable <= 1'b1;
    settle(6);
    cmp("enable load", 24'h000003, cnt);
    ticks(3);
    cmp("reset reqs", 24'h000001, nSys);
    cmp("reload after time-out", 24'h000003, cnt);
    cmp("flags", 24'h000001, {22'h0, flags});
  endtask
  task automatic tStop;
    @(posedge clk) inStop <= 1'b1;
    ticks(1);
    cmp("count down", 24'h000002, cnt);
    core.kick;
    settle(1);
    cmp("refresh load", 24'h000003, cnt);
    ticks(3);
    cmp("stop reqs", 24'h000001, nStop);
    cmp("reset reqs", 24'h000001, nSys);
    cmp("flags", 24'h000003, {22'h0, flags});
    cmp("time-out pulses", 24'h000002, nPulse);
  endtask
  task automatic endOfTest;
    $display("Comparisons %0d, mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    {rstn, tick, enable, resetMode, inStop} = 5'b00010;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    tBroken;
    tReload;
    tStop;
    endOfTest;
  end
endmodule
`default_nettype wire
